/* File: hdl/phc_pkg.sv */
// constants, register map and types of the packet handler configuration block
package phc_pkg;
	// register offsets
	localparam logic [5:0] ADDR_FIFO_THRESHOLD_SETTING = 6'h03;
	localparam logic [5:0] ADDR_SYNC_HI = 6'h04;
	localparam logic [5:0] ADDR_SYNC_LO = 6'h05;
	localparam logic [5:0] ADDR_PKT_LEN = 6'h06;
	localparam logic [5:0] ADDR_PKT_CTRL1 = 6'h07;
	localparam logic [5:0] ADDR_LEN_MODE = 6'h08;
	localparam logic [5:0] ADDR_DEV_ADDR = 6'h09;
	localparam logic [5:0] ADDR_RX_COUNT = 6'h3B;
	localparam logic [5:0] ADDR_RX_FIFO = 6'h3F;
	// reset values
	localparam logic [3:0] RST_FIFO_THRESHOLD_SETTING = 4'h7;
	localparam logic [7:0] RST_SYNC_HI = 8'hD3;
	localparam logic [7:0] RST_SYNC_LO = 8'h91;
	localparam logic [7:0] RST_PKT_LEN = 8'hFF;
	localparam logic [2:0] RST_PQT = 3'h0;
	localparam logic RST_AUTOFLUSH = 1'b0;
	localparam logic RST_APPEND = 1'b1;
	localparam logic [1:0] RST_ADDRESS_FILTER_MODE = 2'h0;
	localparam logic [7:0] RST_DEV_ADDR = 8'h00;
	localparam logic RST_VAR_LEN = 1'b1;
	// field positions of the control register
	localparam int PQT_MSB = 7;
	localparam int PQT_LSB = 5;
	localparam int AUTOFLUSH_BIT = 3;
	localparam int APPEND_BIT = 2;
	localparam int ADDRESS_FILTER_MODE_MSB = 1;
	localparam int ADDRESS_FILTER_MODE_LSB = 0;
	// threshold mapping and preamble quality figures
	localparam logic [6:0] TX_THR_BASE = 7'h3D;
	localparam logic [6:0] RX_THR_BASE = 7'h04;
	localparam logic [6:0] THR_STEP = 7'h04;
	localparam logic [4:0] PQ_DOWN = 5'h08;
	localparam logic [4:0] PQ_SCALE = 5'h04;
	// address filter modes and broadcast values
	localparam logic [1:0] ADR_OFF = 2'h0;
	localparam logic [1:0] ADR_BC0 = 2'h2;
	localparam logic [1:0] ADR_BC0_FF = 2'h3;
	localparam logic [7:0] BCAST_ZERO = 8'h00;
	localparam logic [7:0] BCAST_ONES = 8'hFF;

	typedef struct packed {
		logic [3:0] fifo_threshold_setting;
		logic [7:0] sync_pattern_high;
		logic [7:0] sync_pattern_low;
		logic [7:0] packet_length_limit;
		logic [2:0] preamble_quality_threshold;
		logic flush_on_bad_crc;
		logic append_rx_status;
		logic [1:0] address_filter_mode;
		logic var_len;
		logic [7:0] dev_addr;
	} phc_cfg_t;

	typedef struct packed {
		logic [7:0] rssi;
		logic [6:0] lqi;
		logic crc_ok;
	} phc_status_t;

	typedef enum logic [2:0] {
		ST_HUNT = 3'b001,
		ST_DATA = 3'b010,
		ST_STAT = 3'b100
	} phc_state_t;
endpackage

/* File: hdl/phc_packet_handler.sv */
// receive packet handler: registers, sync gating, length, address filter, rx fifo
`timescale 1ns/1ps
// Function
// R1 - tx threshold is 61 minus 4 times setting, rx threshold 4 times setting plus 4
// R2 - threshold flag rises when fifo byte count meets the threshold
// R3 - sync pattern high byte from its register, reset 0xD3
// R4 - sync pattern low byte from its register, reset 0x91
// R5 - fixed length mode uses the length register as exact length, reset 0xFF
// R6 - variable length mode uses the length register as the largest length
// R7 - variable length mode reads the length from first byte after sync
// R8 - host never programs the length register with zero
// R9 - quality counter goes up one for each bit differing from the previous
// R10 - quality counter goes down eight for each bit equal to the previous
// R11 - sync accepted only when quality counter reaches four times threshold
// R12 - threshold zero accepts every sync word without gating
// R13 - autoflush bit flushes the rx fifo on a bad crc, resets to zero
// R14 - host uses autoflush only when the whole packet fits the rx fifo
// R15 - status append bit, set at reset, appends two bytes per packet
// R16 - status bytes carry signal strength, link quality and crc passed
// R17 - mode 00 no filter, mode 01 own address only
// R18 - mode 10 adds broadcast 0x00, mode 11 adds 0x00 and 0xFF
// R19 - address byte compared with the device address register
// R20 - packet failing the address check leaves no bytes in the rx fifo
module phc_packet_handler #(parameter int AW = 6, parameter int PQ_W = 5) (
	input wire logic i_ref_clk,
	input wire logic i_nrst,
	input wire logic [5:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic i_reg_we,
	input wire logic i_reg_re,
	output logic [7:0] o_reg_rdata,
	input wire logic i_rx_bit,
	input wire logic i_rx_valid,
	input wire phc_pkg::phc_status_t i_status,
	input wire logic [6:0] i_tx_count,
	output logic o_rx_thr,
	output logic o_tx_thr,
	output logic o_sync_found
);
	localparam int DEPTH = 1 << AW;
	localparam logic [PQ_W-1:0] PQ_MAX = '1;
	phc_pkg::phc_cfg_t cfg, next_cfg;
	phc_pkg::phc_state_t state, next_state;
	phc_pkg::phc_status_t stat, next_stat;
	logic [7:0] mem [DEPTH];
	logic [AW:0] wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr, pkt_start, next_pkt_start, cnt;
	logic [PQ_W-1:0] pq, next_pq;
	logic prev_bit, next_prev_bit, stat_idx, next_stat_idx;
	logic [15:0] sync_sr, next_sync_sr, sync_word;
	logic [2:0] bit_cnt, next_bit_cnt;
	logic [7:0] byte_sr, next_byte_sr, new_byte, wdata, next_rdata;
	logic [8:0] idx, next_idx, total, next_total;
	logic [6:0] tx_thr, rx_thr;
	logic we, drop_len, drop_addr, end_pkt, sync_hit, addr_ok, next_rx_thr, next_tx_thr;
	// threshold mapping and fill level [R1]
	assign tx_thr = phc_pkg::TX_THR_BASE - phc_pkg::THR_STEP * {3'h0, cfg.fifo_threshold_setting};
	assign rx_thr = phc_pkg::RX_THR_BASE + phc_pkg::THR_STEP * {3'h0, cfg.fifo_threshold_setting};
	assign cnt = wr_ptr - rd_ptr;
	assign new_byte = {byte_sr[6:0], i_rx_bit};
	assign sync_word = {cfg.sync_pattern_high, cfg.sync_pattern_low}; // [R3] [R4]
	// quality gated sync match [R11] [R12]
	assign sync_hit = i_rx_valid && ({sync_sr[14:0], i_rx_bit} == sync_word) &&
		(cfg.preamble_quality_threshold == 3'h0 ||
		pq >= phc_pkg::PQ_SCALE * {2'h0, cfg.preamble_quality_threshold});
	// address filter by mode [R17] [R18] [R19]
	assign addr_ok = (new_byte == cfg.dev_addr) ||
		((cfg.address_filter_mode == phc_pkg::ADR_BC0 ||
		cfg.address_filter_mode == phc_pkg::ADR_BC0_FF) && new_byte == phc_pkg::BCAST_ZERO) ||
		(cfg.address_filter_mode == phc_pkg::ADR_BC0_FF && new_byte == phc_pkg::BCAST_ONES);
	// register file next values and read mux
	always_comb begin
		next_cfg = cfg;
		next_rdata = 8'h00;
		if (i_reg_we) begin
			if (i_reg_addr == phc_pkg::ADDR_FIFO_THRESHOLD_SETTING) begin
				next_cfg.fifo_threshold_setting = i_reg_wdata[3:0];
			end else if (i_reg_addr == phc_pkg::ADDR_SYNC_HI) begin
				next_cfg.sync_pattern_high = i_reg_wdata;
			end else if (i_reg_addr == phc_pkg::ADDR_SYNC_LO) begin
				next_cfg.sync_pattern_low = i_reg_wdata;
			end else if (i_reg_addr == phc_pkg::ADDR_PKT_LEN) begin
				next_cfg.packet_length_limit = i_reg_wdata;
			end else if (i_reg_addr == phc_pkg::ADDR_PKT_CTRL1) begin
				next_cfg.preamble_quality_threshold = i_reg_wdata[phc_pkg::PQT_MSB:phc_pkg::PQT_LSB];
				next_cfg.flush_on_bad_crc = i_reg_wdata[phc_pkg::AUTOFLUSH_BIT];
				next_cfg.append_rx_status = i_reg_wdata[phc_pkg::APPEND_BIT];
				next_cfg.address_filter_mode =
					i_reg_wdata[phc_pkg::ADDRESS_FILTER_MODE_MSB:phc_pkg::ADDRESS_FILTER_MODE_LSB];
			end else if (i_reg_addr == phc_pkg::ADDR_LEN_MODE) begin
				next_cfg.var_len = i_reg_wdata[0];
			end else if (i_reg_addr == phc_pkg::ADDR_DEV_ADDR) begin
				next_cfg.dev_addr = i_reg_wdata;
			end
		end
		if (i_reg_re) begin
			if (i_reg_addr == phc_pkg::ADDR_FIFO_THRESHOLD_SETTING) begin
				next_rdata = {4'h0, cfg.fifo_threshold_setting};
			end else if (i_reg_addr == phc_pkg::ADDR_SYNC_HI) begin
				next_rdata = cfg.sync_pattern_high;
			end else if (i_reg_addr == phc_pkg::ADDR_SYNC_LO) begin
				next_rdata = cfg.sync_pattern_low;
			end else if (i_reg_addr == phc_pkg::ADDR_PKT_LEN) begin
				next_rdata = cfg.packet_length_limit;
			end else if (i_reg_addr == phc_pkg::ADDR_PKT_CTRL1) begin
				next_rdata = {cfg.preamble_quality_threshold, 1'b0, cfg.flush_on_bad_crc,
					cfg.append_rx_status, cfg.address_filter_mode};
			end else if (i_reg_addr == phc_pkg::ADDR_LEN_MODE) begin
				next_rdata = {7'h00, cfg.var_len};
			end else if (i_reg_addr == phc_pkg::ADDR_DEV_ADDR) begin
				next_rdata = cfg.dev_addr;
			end else if (i_reg_addr == phc_pkg::ADDR_RX_COUNT) begin
				next_rdata = {{(7 - AW){1'b0}}, cnt};
			end else if (i_reg_addr == phc_pkg::ADDR_RX_FIFO && cnt != '0) begin
				next_rdata = mem[rd_ptr[AW-1:0]];
			end
		end
	end
	// receive path: quality counter, sync hunt, bytes, status, fifo pointers
	always_comb begin
		next_state = state;
		next_pq = pq;
		next_prev_bit = prev_bit;
		next_sync_sr = sync_sr;
		next_bit_cnt = bit_cnt;
		next_byte_sr = byte_sr;
		next_idx = idx;
		next_total = total;
		next_pkt_start = pkt_start;
		next_stat = stat;
		next_stat_idx = stat_idx;
		next_wr_ptr = wr_ptr;
		next_rd_ptr = rd_ptr;
		we = 1'b0;
		wdata = new_byte;
		drop_len = 1'b0;
		drop_addr = 1'b0;
		end_pkt = 1'b0;
		if (i_rx_valid) begin
			next_prev_bit = i_rx_bit;
			next_sync_sr = {sync_sr[14:0], i_rx_bit};
			if (i_rx_bit != prev_bit) begin
				next_pq = (pq == PQ_MAX) ? pq : pq + 1'b1; // [R9]
			end else begin
				next_pq = (pq < phc_pkg::PQ_DOWN) ? '0 : pq - phc_pkg::PQ_DOWN; // [R10]
			end
		end
		case (state)
			phc_pkg::ST_HUNT: begin
				if (sync_hit) begin // [R11] [R12]
					next_state = phc_pkg::ST_DATA;
					next_bit_cnt = 3'h0;
					next_idx = 9'h000;
					next_pkt_start = wr_ptr;
					next_total = {1'b0, cfg.packet_length_limit}; // [R5]
				end
			end
			phc_pkg::ST_DATA: begin
				if (i_rx_valid) begin
					next_byte_sr = new_byte;
					next_bit_cnt = bit_cnt + 1'b1;
					if (bit_cnt == 3'h7) begin
						we = 1'b1;
						next_idx = idx + 1'b1;
						if (cfg.var_len && idx == 9'h000) begin
							next_total = {1'b0, new_byte} + 1'b1; // [R7]
							drop_len = (new_byte == 8'h00) ||
								(new_byte > cfg.packet_length_limit); // [R6] [R8]
						end
						drop_addr = (cfg.address_filter_mode != phc_pkg::ADR_OFF) &&
							(idx == {8'h00, cfg.var_len}) && !addr_ok; // [R17] [R18]
						if (drop_len || drop_addr) begin
							we = 1'b0;
							next_state = phc_pkg::ST_HUNT;
						end else if (!(cfg.var_len && idx == 9'h000) && next_idx == total) begin
							next_stat = i_status;
							next_stat_idx = 1'b0;
							if (cfg.append_rx_status) begin
								next_state = phc_pkg::ST_STAT; // [R15]
							end else begin
								end_pkt = 1'b1;
							end
						end
					end
				end
			end
			phc_pkg::ST_STAT: begin
				we = 1'b1; // strength byte, then crc flag over link quality
				wdata = stat_idx ? {stat.crc_ok, stat.lqi} : stat.rssi; // [R16]
				next_stat_idx = 1'b1;
				end_pkt = stat_idx;
			end
			default: begin
				next_state = phc_pkg::ST_HUNT;
			end
		endcase
		if (end_pkt) begin
			next_state = phc_pkg::ST_HUNT;
		end
		if (i_reg_re && i_reg_addr == phc_pkg::ADDR_RX_FIFO && cnt != '0) begin // host pop
			next_rd_ptr = rd_ptr + 1'b1;
		end
		if (we && cnt != DEPTH[AW:0]) begin
			next_wr_ptr = wr_ptr + 1'b1;
		end
		if (drop_len || drop_addr) begin
			next_wr_ptr = pkt_start; // [R20]
		end
		if (end_pkt && cfg.flush_on_bad_crc && !next_stat.crc_ok) begin
			next_wr_ptr = '0; // [R13]
			next_rd_ptr = '0;
		end
	end
	// threshold flags [R2]
	assign next_rx_thr = {{(7 - AW){1'b0}}, next_wr_ptr - next_rd_ptr} >= rx_thr;
	assign next_tx_thr = i_tx_count >= tx_thr;
	// state registers
	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			cfg <= '{phc_pkg::RST_FIFO_THRESHOLD_SETTING, phc_pkg::RST_SYNC_HI, phc_pkg::RST_SYNC_LO,
				phc_pkg::RST_PKT_LEN, phc_pkg::RST_PQT, phc_pkg::RST_AUTOFLUSH,
				phc_pkg::RST_APPEND, phc_pkg::RST_ADDRESS_FILTER_MODE, phc_pkg::RST_VAR_LEN,
				phc_pkg::RST_DEV_ADDR};
			state <= phc_pkg::ST_HUNT;
			stat <= '0;
			stat_idx <= 1'b0;
			wr_ptr <= '0;
			rd_ptr <= '0;
			pkt_start <= '0;
			pq <= '0;
			prev_bit <= 1'b0;
			sync_sr <= 16'h0000;
			bit_cnt <= 3'h0;
			byte_sr <= 8'h00;
			idx <= 9'h000;
			total <= 9'h000;
			o_reg_rdata <= 8'h00;
			o_rx_thr <= 1'b0;
			o_tx_thr <= 1'b0;
			o_sync_found <= 1'b0;
		end else begin
			cfg <= next_cfg;
			state <= next_state;
			stat <= next_stat;
			stat_idx <= next_stat_idx;
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			pkt_start <= next_pkt_start;
			pq <= next_pq;
			prev_bit <= next_prev_bit;
			sync_sr <= next_sync_sr;
			bit_cnt <= next_bit_cnt;
			byte_sr <= next_byte_sr;
			idx <= next_idx;
			total <= next_total;
			o_reg_rdata <= next_rdata;
			o_rx_thr <= next_rx_thr;
			o_tx_thr <= next_tx_thr;
			o_sync_found <= (state == phc_pkg::ST_HUNT) && sync_hit;
		end
	end
	// fifo storage, written while not full
	always_ff @(posedge i_ref_clk) begin
		if (we && cnt != DEPTH[AW:0]) begin
			mem[wr_ptr[AW-1:0]] <= wdata;
		end
	end
	// checks
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_nrst);
	thr_top_map_a: assert property (cfg.fifo_threshold_setting == 4'hF |-> // [R1]
		tx_thr == 7'h01 && rx_thr == 7'h40) else $error("threshold map wrong");
	rx_thr_flag_a: assert property (##1 o_rx_thr == // [R2]
		({{(7 - AW){1'b0}}, cnt} >= $past(rx_thr))) else $error("rx threshold flag wrong");
	sync_reset_a: assert property (@(posedge i_ref_clk) disable iff (1'b0) // [R3] [R4]
		!$past(i_nrst) && i_nrst |-> sync_word == 16'hD391 && cfg.packet_length_limit == 8'hFF
		&& cfg.append_rx_status && !cfg.flush_on_bad_crc) else $error("reset values wrong");
	pq_up_a: assert property (i_rx_valid && i_rx_bit != prev_bit && pq != PQ_MAX |=> // [R9]
		pq == $past(pq) + 1'b1) else $error("quality count up wrong");
	pq_down_a: assert property (i_rx_valid && i_rx_bit == prev_bit && pq >= 5'h08 |=> // [R10]
		pq == $past(pq) - 5'h08) else $error("quality count down wrong");
	sync_gate_a: assert property (state == phc_pkg::ST_HUNT ##1 state == phc_pkg::ST_DATA |-> // [R11]
		$past(cfg.preamble_quality_threshold) == 3'h0 ||
		$past(pq) >= 5'h04 * $past({2'h0, cfg.preamble_quality_threshold}))
		else $error("sync taken below quality");
	pqt_zero_a: assert property (state == phc_pkg::ST_HUNT && cfg.preamble_quality_threshold == 3'h0 // [R12]
		&& i_rx_valid && {sync_sr[14:0], i_rx_bit} == sync_word |=> state == phc_pkg::ST_DATA
		&& o_sync_found) else $error("ungated sync missed");
	fixed_len_a: assert property (state == phc_pkg::ST_HUNT ##1 state == phc_pkg::ST_DATA |-> // [R5]
		total == {1'b0, $past(cfg.packet_length_limit)}) else $error("fixed length wrong");
	len_drop_a: assert property (drop_len |=> state == phc_pkg::ST_HUNT && // [R6]
		wr_ptr == $past(pkt_start)) else $error("oversize packet kept");
	addr_drop_a: assert property (drop_addr |=> wr_ptr == $past(pkt_start) && // [R20]
		state == phc_pkg::ST_HUNT) else $error("filtered packet kept");
	flush_crc_a: assert property (end_pkt && cfg.flush_on_bad_crc && !stat.crc_ok && // [R13]
		state == phc_pkg::ST_STAT |=> cnt == '0) else $error("bad crc not flushed");
	stat_pair_a: assert property (state == phc_pkg::ST_DATA ##1 state == phc_pkg::ST_STAT |-> // [R15]
		##1 state == phc_pkg::ST_STAT ##1 state == phc_pkg::ST_HUNT)
		else $error("status bytes not paired");
	sync_seen_c: cover property (o_sync_found);
	addr_drop_c: cover property (drop_addr);
	status_c: cover property (state == phc_pkg::ST_STAT && stat_idx);
	flush_c: cover property (end_pkt && cfg.flush_on_bad_crc && !next_stat.crc_ok);
endmodule

/* File: testbench/phc_rx_source.sv */
// bit source model: serialises bytes msb first toward the packet handler
`timescale 1ns/1ps
module phc_rx_source (
	input wire logic i_ref_clk,
	output logic o_bit,
	output logic o_valid
);
	// line idles low before the first byte
	initial begin
		o_bit = 1'b0;
		o_valid = 1'b0;
	end

	// one valid pulse per bit; between pulses the line shows the inverse, never stale data
	task automatic send_byte(input logic [7:0] b, input int gap);
		for (int i = 7; i >= 0; i--) begin
			@(negedge i_ref_clk);
			o_bit = b[i];
			o_valid = 1'b1;
			@(negedge i_ref_clk);
			o_valid = 1'b0;
			o_bit = ~b[i];
			repeat (gap) @(negedge i_ref_clk);
		end
	endtask
endmodule

/* File: testbench/test_phc_packet_handler.sv */
// self-checking bench of the packet handler configuration block
`timescale 1ns/1ps
module test_phc_packet_handler;
	logic i_ref_clk = 1'b0;
	logic i_nrst = 1'b0;
	logic [5:0] i_reg_addr = 6'h00;
	logic [7:0] i_reg_wdata = 8'h00;
	logic i_reg_we = 1'b0;
	logic i_reg_re = 1'b0;
	logic [7:0] o_reg_rdata;
	logic i_rx_bit;
	logic i_rx_valid;
	phc_pkg::phc_status_t i_status = 16'hC457;
	logic [6:0] i_tx_count = 7'h00;
	logic o_rx_thr;
	logic o_tx_thr;
	logic o_sync_found;
	int failures = 0;
	int n_checks = 0;
	int n_sync = 0;
	logic ok;
	// register reset values and one unmapped place: address, read data
	logic [13:0] rows [8] = '{{6'h04, 8'hD3}, {6'h05, 8'h91}, {6'h06, 8'hFF}, {6'h07, 8'h04},
		{6'h03, 8'h07}, {6'h08, 8'h01}, {6'h09, 8'h00}, {6'h20, 8'h00}};
	logic [7:0] exp6 [6] = '{8'h03, 8'h5A, 8'h3C, 8'h3C, 8'hC4, 8'hAB};
	logic [7:0] adrs [4] = '{8'h5A, 8'h33, 8'h00, 8'hFF};

	phc_packet_handler DUT (
		.i_ref_clk(i_ref_clk),
		.i_nrst(i_nrst),
		.i_reg_addr(i_reg_addr),
		.i_reg_wdata(i_reg_wdata),
		.i_reg_we(i_reg_we),
		.i_reg_re(i_reg_re),
		.o_reg_rdata(o_reg_rdata),
		.i_rx_bit(i_rx_bit),
		.i_rx_valid(i_rx_valid),
		.i_status(i_status),
		.i_tx_count(i_tx_count),
		.o_rx_thr(o_rx_thr),
		.o_tx_thr(o_tx_thr),
		.o_sync_found(o_sync_found)
	);
	phc_rx_source src (
		.i_ref_clk(i_ref_clk),
		.o_bit(i_rx_bit),
		.o_valid(i_rx_valid)
	);

	// clock and sync pulse counter
	always #4 i_ref_clk = ~i_ref_clk;
	always @(posedge i_ref_clk) begin
		if (o_sync_found === 1'b1) n_sync++;
	end

	// comparison, register write, register read with compare, fifo pops
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("Error at %0t: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		@(negedge i_ref_clk);
		i_reg_addr = a;
		i_reg_wdata = d;
		i_reg_we = 1'b1;
		@(negedge i_ref_clk);
		i_reg_we = 1'b0;
	endtask
	task automatic rdc(input logic [5:0] a, input logic [7:0] exp);
		@(negedge i_ref_clk);
		i_reg_addr = a;
		i_reg_re = 1'b1;
		@(negedge i_ref_clk);
		i_reg_re = 1'b0;
		check(o_reg_rdata, exp);
	endtask
	task automatic pop(input int n);
		repeat (n) begin
			@(negedge i_ref_clk);
			i_reg_addr = 6'h3F;
			i_reg_re = 1'b1;
			@(negedge i_ref_clk);
			i_reg_re = 1'b0;
		end
	endtask
	// lead-in (flat 0x00 pair when pre is 0), sync word 0xAAAB, two bytes, then filler
	task automatic pkt(input int pre, input int gap, input logic [7:0] b0,
		input logic [7:0] b1, input int nf);
		if (pre == 0) repeat (2) src.send_byte(8'h00, gap);
		repeat (pre) src.send_byte(8'hAA, gap);
		src.send_byte(8'hAA, gap);
		src.send_byte(8'hAB, gap);
		src.send_byte(b0, gap);
		src.send_byte(b1, gap);
		repeat (nf) src.send_byte(8'h3C, gap);
		repeat (4) @(negedge i_ref_clk);
	endtask
	task automatic stop_test;
		$display("checks %0d, failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask

	// watchdog well beyond the expected run length
	initial begin
		repeat (40000) @(posedge i_ref_clk);
		failures++;
		stop_test;
	end

	// main sequence
	initial begin
		repeat (6) @(negedge i_ref_clk);
		i_nrst = 1'b1;
		for (int r = 0; r < 8; r++) rdc(rows[r][13:8], rows[r][7:0]);
		for (int s = 0; s < 16; s++) begin
			wr(6'h03, 8'(s));
			i_tx_count = 7'(61 - 4 * s);
			repeat (3) @(negedge i_ref_clk);
			check({7'h00, o_tx_thr}, 8'h01);
			i_tx_count = 7'(60 - 4 * s);
			repeat (3) @(negedge i_ref_clk);
			check({7'h00, o_tx_thr}, 8'h00);
		end
		wr(6'h04, 8'hAA);
		wr(6'h05, 8'hAB);
		rdc(6'h04, 8'hAA);
		pkt(4, 0, 8'h03, 8'h5A, 2);
		check(8'(n_sync), 8'h01);
		rdc(6'h3B, 8'h06);
		check({7'h00, o_rx_thr}, 8'h00);
		wr(6'h03, 8'h00);
		repeat (2) @(negedge i_ref_clk);
		check({7'h00, o_rx_thr}, 8'h01);
		wr(6'h03, 8'h01);
		repeat (2) @(negedge i_ref_clk);
		check({7'h00, o_rx_thr}, 8'h00);
		for (int k = 0; k < 6; k++) rdc(6'h3F, exp6[k]);
		rdc(6'h3F, 8'h00);
		// quality gate 28: flat lead-in reaches 15, long preamble saturates
		wr(6'h07, 8'hE4);
		pkt(0, 0, 8'h03, 8'h5A, 2);
		check(8'(n_sync), 8'h01);
		pkt(6, 0, 8'h03, 8'h5A, 2);
		check(8'(n_sync), 8'h02);
		pop(6);
		wr(6'h09, 8'h5A);
		for (int m = 0; m < 4; m++) begin
			wr(6'h07, 8'h04 | 8'(m));
			for (int j = 0; j < 4; j++) begin
				pkt(4, 0, 8'h03, adrs[j], 2);
				ok = m == 0 || j == 0 || (m >= 2 && j == 2) || (m == 3 && j == 3);
				rdc(6'h3B, ok ? 8'h06 : 8'h00);
				if (ok) pop(6);
			end
		end
		wr(6'h07, 8'h04);
		wr(6'h06, 8'h03); // nonzero limit only
		pkt(4, 0, 8'h04, 8'h5A, 3);
		rdc(6'h3B, 8'h00);
		wr(6'h08, 8'h00);
		pkt(4, 0, 8'h5A, 8'h3C, 1);
		rdc(6'h3B, 8'h05);
		pop(5);
		wr(6'h08, 8'h01);
		wr(6'h07, 8'h0C); // six-byte packets fit the fifo
		i_status.crc_ok = 1'b0;
		pkt(4, 2, 8'h03, 8'h5A, 2);
		rdc(6'h3B, 8'h00);
		i_status.crc_ok = 1'b1;
		pkt(4, 0, 8'h03, 8'h5A, 2);
		rdc(6'h3B, 8'h06);
		stop_test;
	end
endmodule
